// ---- include/vector_pkg.sv ----
// Constants shared by the exception vector selection unit
package vector_pkg;
	// ------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_NATIVE = 2'h0;
	localparam logic [1:0] MODE_EMU16 = 2'h1;
	localparam logic [1:0] MODE_EMU8 = 2'h2;

	// ------------------------------------------------------------
	// Vector locations (low byte address, high byte is the next one)
	// ------------------------------------------------------------
	localparam logic [7:0] VECTOR_BANK = 8'h00;
	localparam logic [15:0] NAT_IRQ_VEC = 16'hFFDE;
	localparam logic [15:0] NAT_RSVD_VEC = 16'hFFDC;
	localparam logic [15:0] NAT_NMI_VEC = 16'hFFDA;
	localparam logic [15:0] NAT_ABORT_VEC = 16'hFFD8;
	localparam logic [15:0] NAT_BREAK_VEC = 16'hFFD6;
	localparam logic [15:0] NAT_TRAP_VEC = 16'hFFD4;
	localparam logic [15:0] EMU16_IRQ_VEC = 16'hFFEE;
	localparam logic [15:0] EMU16_RSVD_VEC = 16'hFFEC;
	localparam logic [15:0] EMU16_NMI_VEC = 16'hFFEA;
	localparam logic [15:0] EMU16_ABORT_VEC = 16'hFFE8;
	localparam logic [15:0] EMU16_BREAK_VEC = 16'hFFE6;
	localparam logic [15:0] EMU16_TRAP_VEC = 16'hFFE4;
	localparam logic [15:0] EMU8_IRQ_BREAK_VEC = 16'hFFFE;
	localparam logic [15:0] EMU8_RESET_VEC = 16'hFFFC;
	localparam logic [15:0] EMU8_NMI_VEC = 16'hFFFA;
	localparam logic [15:0] EMU8_ABORT_VEC = 16'hFFF8;
	localparam logic [15:0] EMU8_RSVD_VEC = 16'hFFF6;
	localparam logic [15:0] EMU8_TRAP_VEC = 16'hFFF4;

	// ------------------------------------------------------------
	// Status register bit positions
	// ------------------------------------------------------------
	localparam int P_IRQ_DISABLE_BIT = 2;
	localparam int P_DECIMAL_BIT = 3;

	// ------------------------------------------------------------
	// Software register map and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STAT_OFFSET = 4'h4;
	localparam logic [3:0] COUNT_OFFSET = 4'h8;
	localparam int CTRL_IRQ_GATE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam int STAT_SRC_LSB = 0;
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_MODE_LSB = 8;

	// ------------------------------------------------------------
	// Exception sources, highest priority first
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_RESET,
		SRC_ABORT,
		SRC_NMI,
		SRC_IRQ,
		SRC_BREAK,
		SRC_TRAP
	} src_t;
endpackage

// ---- core/interrupt_vector_select.sv ----
// Exception vector selection and vector fetch sequencer
// Notes on behaviour
// RL1 - Native mode vectors: irq DE, nmi DA, abort D8, break D6, trap D4.
// RL2 - 16-bit emulation vectors: irq EE, nmi EA, abort E8, break E6, trap E4.
// RL3 - 8-bit emulation: irq and break share FE; nmi FA, abort F8, trap F4.
// RL4 - Reset always fetches its start vector from FFFC/FFFD.
// RL5 - Vector pull output is low during both vector read cycles only.
// RL6 - Taking any exception clears decimal flag and sets interrupt disable.
// RL7 - Vector reads always address bank zero.
// RL8 - Low byte read first at even address, high byte next, then loaded into PC.
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_select (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// Interrupt pins, active low, asynchronous
	input wire logic IRQ_N_I,
	input wire logic NMI_N_I,
	input wire logic ABORT_N_I,
	// Software trap strobes and processor state
	input wire logic BREAK_I,
	input wire logic TRAP_I,
	input wire logic [1:0] MODE_I,
	input wire logic [7:0] STATUS_P_I,
	// Memory read port
	output logic [23:0] ADDR_O,
	output logic RD_O,
	input wire logic [7:0] DATA_I,
	output logic VEC_PULL_N_O,
	// Results to the processor
	output logic [15:0] PC_O,
	output logic PC_LOAD_O,
	output logic [7:0] STATUS_P_O,
	output logic BUSY_O,
	// Register port
	input wire logic [3:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH_LO,
		ST_FETCH_HI,
		ST_FINISH
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic [2:0] irq_sync_reg;
	logic [2:0] nmi_sync_reg;
	logic [2:0] abort_sync_reg;
	logic irq_lvl_reg;
	logic nmi_lvl_reg;
	logic abort_lvl_reg;
	logic nmi_pend_reg;
	logic abort_pend_reg;
	logic reset_pend_reg;
	logic break_pend_reg;
	logic trap_pend_reg;
	logic irq_take;
	logic any_req;
	vector_pkg::src_t src_next;
	vector_pkg::src_t src_reg;
	logic [15:0] vec_addr;
	logic [15:0] vec_reg;
	logic [1:0] mode_reg;
	logic [7:0] lo_byte_reg;
	logic [31:0] ctrl_reg;
	logic [15:0] count_reg;
	logic nmi_fall;
	logic abort_fall;
	logic start;

	// ------------------------------------------------------------
	// Pin synchronisers: a level counts once stages two and three agree
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			irq_sync_reg <= 3'h7;
			nmi_sync_reg <= 3'h7;
			abort_sync_reg <= 3'h7;
		end else begin
			irq_sync_reg <= {irq_sync_reg[1:0], IRQ_N_I};
			nmi_sync_reg <= {nmi_sync_reg[1:0], NMI_N_I};
			abort_sync_reg <= {abort_sync_reg[1:0], ABORT_N_I};
		end
	end

	// Filtered pin levels, updated only when the two late stages agree
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			irq_lvl_reg <= 1'b1;
			nmi_lvl_reg <= 1'b1;
			abort_lvl_reg <= 1'b1;
		end else begin
			if (irq_sync_reg[1] == irq_sync_reg[2])
				irq_lvl_reg <= irq_sync_reg[2];
			if (nmi_sync_reg[1] == nmi_sync_reg[2])
				nmi_lvl_reg <= nmi_sync_reg[2];
			if (abort_sync_reg[1] == abort_sync_reg[2])
				abort_lvl_reg <= abort_sync_reg[2];
		end
	end

	// Falling edges of the edge-triggered pins
	assign nmi_fall = nmi_lvl_reg && (nmi_sync_reg[1] == nmi_sync_reg[2]) && !nmi_sync_reg[2];
	assign abort_fall = abort_lvl_reg && (abort_sync_reg[1] == abort_sync_reg[2])
		&& !abort_sync_reg[2];

	// ------------------------------------------------------------
	// Pending requests; a new event wins over the clear on acceptance
	// ------------------------------------------------------------
	assign start = (state_reg == ST_IDLE) && any_req;

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			reset_pend_reg <= 1'b1; // Start vector is fetched after reset
			nmi_pend_reg <= 1'b0;
			abort_pend_reg <= 1'b0;
			break_pend_reg <= 1'b0;
			trap_pend_reg <= 1'b0;
		end else begin
			if (start && src_next == vector_pkg::SRC_RESET)
				reset_pend_reg <= 1'b0;
			nmi_pend_reg <= nmi_fall || (nmi_pend_reg && !(start && src_next == vector_pkg::SRC_NMI));
			abort_pend_reg <= abort_fall
				|| (abort_pend_reg && !(start && src_next == vector_pkg::SRC_ABORT));
			break_pend_reg <= BREAK_I
				|| (break_pend_reg && !(start && src_next == vector_pkg::SRC_BREAK));
			trap_pend_reg <= TRAP_I
				|| (trap_pend_reg && !(start && src_next == vector_pkg::SRC_TRAP));
		end
	end

	// Maskable request is a level gated by the disable flag and control bit
	assign irq_take = !irq_lvl_reg && !STATUS_P_I[vector_pkg::P_IRQ_DISABLE_BIT]
		&& ctrl_reg[vector_pkg::CTRL_IRQ_GATE_BIT];
	assign any_req = reset_pend_reg || abort_pend_reg || nmi_pend_reg || irq_take
		|| break_pend_reg || trap_pend_reg;

	// Priority choice among pending sources
	always_comb begin
		if (reset_pend_reg)
			src_next = vector_pkg::SRC_RESET;
		else if (abort_pend_reg)
			src_next = vector_pkg::SRC_ABORT;
		else if (nmi_pend_reg)
			src_next = vector_pkg::SRC_NMI;
		else if (irq_take)
			src_next = vector_pkg::SRC_IRQ;
		else if (break_pend_reg)
			src_next = vector_pkg::SRC_BREAK;
		else
			src_next = vector_pkg::SRC_TRAP;
	end

	// ------------------------------------------------------------
	// Vector table lookup by mode and source
	// ------------------------------------------------------------
	always_comb begin
		vec_addr = vector_pkg::EMU8_RESET_VEC;
		if (src_next == vector_pkg::SRC_RESET)
			vec_addr = vector_pkg::EMU8_RESET_VEC; // RL4
		else if (MODE_I == vector_pkg::MODE_EMU8) begin
			case (src_next) // RL3
				vector_pkg::SRC_ABORT: vec_addr = vector_pkg::EMU8_ABORT_VEC;
				vector_pkg::SRC_NMI: vec_addr = vector_pkg::EMU8_NMI_VEC;
				vector_pkg::SRC_TRAP: vec_addr = vector_pkg::EMU8_TRAP_VEC;
				default: vec_addr = vector_pkg::EMU8_IRQ_BREAK_VEC;
			endcase
		end else if (MODE_I == vector_pkg::MODE_EMU16) begin
			case (src_next) // RL2
				vector_pkg::SRC_ABORT: vec_addr = vector_pkg::EMU16_ABORT_VEC;
				vector_pkg::SRC_NMI: vec_addr = vector_pkg::EMU16_NMI_VEC;
				vector_pkg::SRC_BREAK: vec_addr = vector_pkg::EMU16_BREAK_VEC;
				vector_pkg::SRC_TRAP: vec_addr = vector_pkg::EMU16_TRAP_VEC;
				default: vec_addr = vector_pkg::EMU16_IRQ_VEC;
			endcase
		end else begin
			case (src_next) // RL1
				vector_pkg::SRC_ABORT: vec_addr = vector_pkg::NAT_ABORT_VEC;
				vector_pkg::SRC_NMI: vec_addr = vector_pkg::NAT_NMI_VEC;
				vector_pkg::SRC_BREAK: vec_addr = vector_pkg::NAT_BREAK_VEC;
				vector_pkg::SRC_TRAP: vec_addr = vector_pkg::NAT_TRAP_VEC;
				default: vec_addr = vector_pkg::NAT_IRQ_VEC;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Fetch sequencer
	// ------------------------------------------------------------
	always_comb begin
		case (state_reg)
			ST_IDLE: state_next = any_req ? ST_FETCH_LO : ST_IDLE;
			ST_FETCH_LO: state_next = ST_FETCH_HI;
			ST_FETCH_HI: state_next = ST_FINISH;
			ST_FINISH: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Latch the chosen source, vector and mode at acceptance
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			src_reg <= vector_pkg::SRC_RESET;
			vec_reg <= vector_pkg::EMU8_RESET_VEC;
			mode_reg <= vector_pkg::MODE_EMU8;
		end else if (start) begin
			src_reg <= src_next;
			vec_reg <= vec_addr;
			mode_reg <= MODE_I;
		end
	end

	// Bus outputs: even address then odd, both in bank zero, vector pull low
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			ADDR_O <= 24'h000000;
			RD_O <= 1'b0;
			VEC_PULL_N_O <= 1'b1;
		end else if (state_next == ST_FETCH_LO) begin
			ADDR_O <= {vector_pkg::VECTOR_BANK, vec_addr}; // RL7
			RD_O <= 1'b1;
			VEC_PULL_N_O <= 1'b0; // RL5
		end else if (state_next == ST_FETCH_HI) begin
			ADDR_O <= {vector_pkg::VECTOR_BANK, vec_reg | 16'h0001}; // RL8
			RD_O <= 1'b1;
			VEC_PULL_N_O <= 1'b0; // RL5
		end else begin
			RD_O <= 1'b0;
			VEC_PULL_N_O <= 1'b1; // RL5
		end
	end

	// Read data arrives one cycle after each read; low byte first
	always_ff @(posedge CLOCK_I) begin
		if (RST_I)
			lo_byte_reg <= 8'h00;
		else if (state_reg == ST_FETCH_HI)
			lo_byte_reg <= DATA_I; // RL8
	end

	// Program counter and status results
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			PC_O <= 16'h0000;
			PC_LOAD_O <= 1'b0;
			STATUS_P_O <= 8'h00;
		end else begin
			PC_LOAD_O <= (state_reg == ST_FINISH);
			if (state_reg == ST_FINISH) begin
				PC_O <= {DATA_I, lo_byte_reg}; // RL8
				STATUS_P_O <= STATUS_P_I;
				STATUS_P_O[vector_pkg::P_DECIMAL_BIT] <= 1'b0; // RL6
				STATUS_P_O[vector_pkg::P_IRQ_DISABLE_BIT] <= 1'b1; // RL6
			end
		end
	end

	// Busy from acceptance until the load cycle
	always_ff @(posedge CLOCK_I) begin
		if (RST_I)
			BUSY_O <= 1'b0;
		else
			BUSY_O <= (state_next != ST_IDLE);
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (RST_I)
			ctrl_reg <= vector_pkg::CTRL_RESET;
		else if (REG_WR_I && REG_ADDR_I == vector_pkg::CTRL_OFFSET)
			ctrl_reg <= {31'h0000_0000, REG_WDATA_I[vector_pkg::CTRL_IRQ_GATE_BIT]};
	end

	// Count of vectors taken; a write clears it, a take in that cycle then counts as one
	always_ff @(posedge CLOCK_I) begin
		if (RST_I)
			count_reg <= vector_pkg::COUNT_RESET;
		else if (state_reg == ST_FINISH)
			count_reg <= (REG_WR_I && REG_ADDR_I == vector_pkg::COUNT_OFFSET)
				? 16'h0001 : count_reg + 16'h0001;
		else if (REG_WR_I && REG_ADDR_I == vector_pkg::COUNT_OFFSET)
			count_reg <= vector_pkg::COUNT_RESET;
	end

	// Read data, valid the cycle after the strobe, zero otherwise
	always_ff @(posedge CLOCK_I) begin
		if (RST_I)
			REG_RDATA_O <= 32'h0000_0000;
		else if (!REG_RD_I)
			REG_RDATA_O <= 32'h0000_0000;
		else begin
			case (REG_ADDR_I)
				vector_pkg::CTRL_OFFSET: REG_RDATA_O <= ctrl_reg;
				vector_pkg::STAT_OFFSET: REG_RDATA_O <= {22'h000000, mode_reg, 3'h0,
					BUSY_O, 1'b0, src_reg};
				vector_pkg::COUNT_OFFSET: REG_RDATA_O <= {16'h0000, count_reg};
				default: REG_RDATA_O <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- dv/vector_memory.sv ----
// Vector memory model answering the unit's read strobe
`timescale 1ns/1ps
`default_nettype none
module vector_memory (
	// Clock and read request
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic [23:0] addr_i,
	// Read data, one cycle after the strobe
	output logic [7:0] data_o
);
	initial data_o = 8'h3C;
	// Data depends on both address bytes; idle cycles toggle so stale data never matches
	always @(posedge clk_i) begin
		if (rd_i)
			data_o <= addr_i[7:0] ^ addr_i[15:8];
		else
			data_o <= ~data_o;
	end
endmodule
`default_nettype wire

// ---- dv/vector_monitor.sv ----
// Checker for vector fetch timing at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module vector_monitor (
	// Clock and reset of the unit
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// Vector fetch bus and results
	input wire logic RD_O,
	input wire logic VEC_PULL_N_O,
	input wire logic [23:0] ADDR_O,
	input wire logic PC_LOAD_O,
	input wire logic [15:0] PC_O,
	input wire logic [7:0] STATUS_P_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);
	// Two read cycles, then release
	sequence two_reads;
		RD_O ##1 RD_O ##1 !RD_O;
	endsequence
	pull_follows_rd_a: assert property (VEC_PULL_N_O == !RD_O)
		else $error("pull flag off read");
	pull_twice_a: assert property ($rose(RD_O) |-> two_reads)
		else $error("read not two cycles");
	bank_zero_a: assert property (RD_O |-> ADDR_O[23:16] == 8'h00)
		else $error("bank not zero");
	even_then_odd_a: assert property ($rose(RD_O) |-> !ADDR_O[0] ##1 ADDR_O == $past(ADDR_O) + 24'h000001)
		else $error("byte order wrong");
	load_after_a: assert property ($rose(RD_O) |-> two_reads ##1 PC_LOAD_O)
		else $error("no load after fetch");
	reset_vec_a: assert property ($fell(RST_I) |=> RD_O && ADDR_O == 24'h00FFFC)
		else $error("start vector wrong");
	flags_set_a: assert property (PC_LOAD_O |-> STATUS_P_O[3:2] == 2'b01)
		else $error("entry flags wrong");
	pc_hold_a: assert property (PC_O != $past(PC_O) |-> PC_LOAD_O)
		else $error("pc changed without load");
	load_lone_a: assert property (PC_LOAD_O |=> !PC_LOAD_O)
		else $error("load too long");
endmodule
bind interrupt_vector_select vector_monitor mon (.CLOCK_I, .RST_I, .RD_O, .VEC_PULL_N_O, .ADDR_O,
	.PC_LOAD_O, .PC_O, .STATUS_P_O);
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the exception vector unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic CLOCK_I = 1'b0;
	logic RST_I = 1'b1;
	logic IRQ_N_I = 1'b1, NMI_N_I = 1'b1, ABORT_N_I = 1'b1, BREAK_I = 1'b0, TRAP_I = 1'b0;
	logic REG_WR_I = 1'b0, REG_RD_I = 1'b0;
	logic [1:0] MODE_I = 2'h0;
	logic [7:0] STATUS_P_I = 8'h08;
	logic [3:0] REG_ADDR_I = 4'h0;
	logic [31:0] REG_WDATA_I = 32'h0, REG_RDATA_O;
	logic [23:0] ADDR_O;
	logic RD_O, VEC_PULL_N_O, PC_LOAD_O, BUSY_O;
	logic [7:0] DATA_I, STATUS_P_O;
	logic [15:0] PC_O;
	int err_total = 0;
	int cmp_count = 0;
	// Vectors per mode: nmi, abort, break, trap, maskable
	logic [15:0] vec_tbl [3][5] = '{
		'{16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4, 16'hFFDE},
		'{16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFEE},
		'{16'hFFFA, 16'hFFF8, 16'hFFFE, 16'hFFF4, 16'hFFFE}};
	always #4 CLOCK_I = ~CLOCK_I;
	interrupt_vector_select dut (.CLOCK_I, .RST_I, .IRQ_N_I, .NMI_N_I, .ABORT_N_I, .BREAK_I,
		.TRAP_I, .MODE_I, .STATUS_P_I, .ADDR_O, .RD_O, .DATA_I, .VEC_PULL_N_O, .PC_O, .PC_LOAD_O,
		.STATUS_P_O, .BUSY_O, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O);
	vector_memory mem (.clk_i(CLOCK_I), .rd_i(RD_O), .addr_i(ADDR_O), .data_o(DATA_I));
	// ------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Value the memory model returns for a vector pair
	function automatic logic [15:0] pc_of(input logic [15:0] v);
		return {v[15:8] ^ (v[7:0] + 8'h01), v[15:8] ^ v[7:0]};
	endfunction
	task end_of_test;
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLOCK_I);
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		REG_WR_I <= 1'b1;
		@(posedge CLOCK_I);
		REG_WR_I <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge CLOCK_I);
		REG_ADDR_I <= a;
		REG_RD_I <= 1'b1;
		@(posedge CLOCK_I);
		REG_RD_I <= 1'b0;
		@(posedge CLOCK_I);
		chk(REG_RDATA_O, e);
	endtask
	task wait_load(input logic [15:0] v);
		int n;
		for (n = 0; n < 40 && PC_LOAD_O !== 1'b1; n++) @(posedge CLOCK_I);
		chk(PC_O, pc_of(v));
		chk(STATUS_P_O, 8'h04);
	endtask
	// Raise one source, then mask further requests once the fetch starts
	task take(input int s, input logic [15:0] v);
		int n;
		repeat (6) @(posedge CLOCK_I);
		STATUS_P_I <= 8'h08;
		case (s)
			0: NMI_N_I <= 1'b0;
			1: ABORT_N_I <= 1'b0;
			2: BREAK_I <= 1'b1;
			3: TRAP_I <= 1'b1;
			default: IRQ_N_I <= 1'b0;
		endcase
		@(posedge CLOCK_I);
		BREAK_I <= 1'b0;
		TRAP_I <= 1'b0;
		for (n = 0; n < 20 && BUSY_O !== 1'b1; n++) @(posedge CLOCK_I);
		{IRQ_N_I, NMI_N_I, ABORT_N_I} <= 3'h7;
		STATUS_P_I <= 8'h0C;
		wait_load(v);
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		wait_load(16'hFFFC);
		rd(4'h0, 32'h1);
		for (int m = 0; m < 3; m++) begin
			for (int s = 0; s < 5; s++) begin
				MODE_I <= 2'(m);
				take(s, vec_tbl[m][s]);
			end
		end
		MODE_I <= 2'h3;
		take(2, 16'hFFD6);
		// Status word: last mode 3 in bits 9:8, idle, last source break (4)
		rd(4'h4, 32'h0000_0304);
		rd(4'h8, 32'h11);
		wr(4'h8, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hC, 32'h0);
		wr(4'h0, 32'h0);
		STATUS_P_I <= 8'h08;
		IRQ_N_I <= 1'b0;
		repeat (12) @(posedge CLOCK_I);
		chk(BUSY_O, 32'h0);
		IRQ_N_I <= 1'b1;
		STATUS_P_I <= 8'h0C;
		repeat (6) @(posedge CLOCK_I);
		wr(4'h0, 32'h1);
		// Break is taken before the pin edge clears the synchroniser; a second
		// break then waits beside the non-maskable request, which wins on priority
		MODE_I <= 2'h0;
		NMI_N_I <= 1'b0;
		BREAK_I <= 1'b1;
		@(posedge CLOCK_I);
		BREAK_I <= 1'b0;
		@(posedge CLOCK_I);
		BREAK_I <= 1'b1;
		@(posedge CLOCK_I);
		BREAK_I <= 1'b0;
		wait_load(16'hFFD6);
		NMI_N_I <= 1'b1;
		@(posedge CLOCK_I);
		wait_load(16'hFFDA);
		@(posedge CLOCK_I);
		wait_load(16'hFFD6);
		// Reset in mid-fetch restarts from the start vector, checked in 16-bit emulation mode (mode 1)
		MODE_I <= 2'h1;
		BREAK_I <= 1'b1;
		@(posedge CLOCK_I);
		BREAK_I <= 1'b0;
		@(posedge CLOCK_I);
		RST_I <= 1'b1;
		repeat (3) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		wait_load(16'hFFFC);
		rd(4'h8, 32'h1);
		end_of_test;
	end
	// Watchdog
	initial begin
		#100000;
		err_total++;
		end_of_test;
	end
endmodule
`default_nettype wire
